// >>> pxcc_consts.vh
// constants for the port extended control and counter registers
`ifndef PXCC_CONSTS_VH
`define PXCC_CONSTS_VH
`define PXCC_ADDR_FCAR       5'h14
`define PXCC_ADDR_LDROP      5'h15
`define PXCC_ADDR_TENCS      5'h16
`define PXCC_ADDR_MODE       5'h17
`define PXCC_ADDR_EDGE       5'h18
`define PXCC_ADDR_CTRL       5'h00
`define PXCC_BIT_SWRESET     15
`define PXCC_BIT_FORCELINK   15
`define PXCC_BIT_JABDIS      14
`define PXCC_BIT_ECHODIS     13
`define PXCC_BIT_HBDIS       12
`define PXCC_SQ_HI           11
`define PXCC_SQ_LO           10
`define PXCC_BIT_STICKYEN    9
`define PXCC_BIT_EOFERR      8
`define PXCC_BIT_TDISC       7
`define PXCC_BIT_TLINK       6
`define PXCC_BIT_BCAST       0
`define PXCC_MODE_HI         10
`define PXCC_MODE_LO         8
`define PXCC_BIT_FARLB       3
`define PXCC_EDGE_HI         15
`define PXCC_EDGE_LO         13
`define PXCC_BIT_LOWPWR      12
`define PXCC_JUMBO_HI        5
`define PXCC_JUMBO_LO        4
`define PXCC_BIT_CONNLB      0
`define PXCC_RST_SQUELCH     2'h0
`define PXCC_RST_MODE        3'h0
`define PXCC_RST_EDGE        3'h1
`define PXCC_RST_JUMBO       2'h0
`define PXCC_RST_ECHODIS     1'h1
`define PXCC_RST_HBDIS       1'h1
`define PXCC_RST_STICKYEN    1'h1
`define PXCC_CNT_MAX         8'hff
`endif

// >>> pxcc_sat_counter.v
// saturating clear-on-read 8-bit event counter
`timescale 1ns/1ps
`include "pxcc_consts.vh"
module pxcc_sat_counter #(
    parameter WIDTH = 8
) (
    input  wire             clk,     // device clock
    input  wire             rstn,    // synchronous reset, active low
    input  wire             pulse,   // one-cycle event pulse
    input  wire             rdClear, // read of this counter
    output reg  [WIDTH-1:0] count    // current count
);
    // read clears; an event in the read cycle starts the new count
    always @(posedge clk) begin
        if (!rstn) begin
            count <= {WIDTH{1'b0}};
        end else if (rdClear) begin
            count <= pulse ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
        end else if (pulse && (count != {WIDTH{1'b1}})) begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

// >>> pxcc_sticky_flag.v
// clear-on-read event flag, set wins over read clear
`timescale 1ns/1ps
module pxcc_sticky_flag (
    input  wire clk,     // device clock
    input  wire rstn,    // synchronous reset, active low
    input  wire pulse,   // one-cycle detection pulse
    input  wire rdClear, // read of the holding register
    output reg  flag     // latched flag
);
    // hold until read, a new event keeps it set
    always @(posedge clk) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (pulse) begin
            flag <= 1'b1;
        end else if (rdClear) begin
            flag <= 1'b0;
        end
    end
endmodule

// >>> pxcc_port_regs.v
// extended control and counter registers for a bank of ports
`timescale 1ns/1ps
`include "pxcc_consts.vh"
module pxcc_port_regs #(
    parameter PORTS = 4,
    parameter PW    = 2
) (
    input  wire             clk,         // device clock
    input  wire             rstn,        // hardware reset, active low
    input  wire [PW-1:0]    mgmtPort,    // addressed port
    input  wire [4:0]       mgmtAddr,    // register address
    input  wire             mgmtWr,      // write strobe
    input  wire             mgmtRd,      // read strobe
    input  wire [15:0]      mgmtWdata,   // write data
    output reg  [15:0]      mgmtRdata,   // read data, valid after read
    input  wire [PORTS-1:0] falseCarrier, // false carrier pulses
    input  wire [PORTS-1:0] linkDrop,    // copper link drop pulses
    input  wire [PORTS-1:0] eofError,    // end-of-frame error pulses
    input  wire [PORTS-1:0] tenDisc,     // 10BASE-T disconnect pulses
    input  wire [PORTS-1:0] tenLinkRaw,  // integrity machine link state
    output wire [PORTS-1:0] tenLinkUp,   // reported 10BASE-T link
    output wire [PORTS-1:0] jabberOff,   // jabber detect disabled
    output wire [PORTS-1:0] echoOff,     // echo disabled
    output wire [PORTS-1:0] heartbeatOff, // heartbeat_test_mode off
    output wire [2*PORTS-1:0] squelch,   // squelch select per port
    output wire [3*PORTS-1:0] mediaMode, // active media mode
    output wire [PORTS-1:0] farLoop,     // far-end loopback enable
    output wire [3*PORTS-1:0] edgeRate,  // edge rate code
    output wire [PORTS-1:0] backplaneLowPower, // reduced power enable
    output wire [2*PORTS-1:0] jumboMode, // jumbo length select
    output wire [PORTS-1:0] connLoop,    // connector loopback enable
    output wire [PORTS-1:0] softReset    // soft reset pulse per port
);
    // broadcast enable of the addressed port steers write fan-out
    wire [PORTS-1:0] bcastEn;
    wire             bcastSel = bcastEn[mgmtPort];
    wire [15:0]      rdWord [0:PORTS-1];

    genvar p;
    generate
        for (p = 0; p < PORTS; p = p + 1) begin : gPort
            wire hit = ({{(32-PW){1'b0}}, mgmtPort} == p);
            wire wr  = mgmtWr && (hit || bcastSel);
            wire rd  = mgmtRd && hit;
            wire swr = wr && (mgmtAddr == `PXCC_ADDR_CTRL) &&
                       mgmtWdata[`PXCC_BIT_SWRESET];
            wire clrSticky;
            reg       forceLink;
            reg       jabDis;
            reg       echoDis;
            reg       hbDis;
            reg [1:0] sq;
            reg       stickyEn;
            reg [2:0] modeActive;
            reg [2:0] modePending;
            reg       farLb;
            reg [2:0] edgeSel;
            reg       bcast;
            reg       lowPwr;
            reg [1:0] jumbo;
            reg       connLb;
            wire [7:0] fcCount;
            wire [7:0] ldCount;
            wire       eofFlag;
            wire       discFlag;
            reg        linkNow;

            assign clrSticky = swr && !stickyEn;

            pxcc_sat_counter #(.WIDTH(8)) uFalseCarrier (
                .clk     (clk),
                .rstn    (rstn),
                .pulse   (falseCarrier[p]),
                .rdClear (rd && (mgmtAddr == `PXCC_ADDR_FCAR)),
                .count   (fcCount)
            );
            pxcc_sat_counter #(.WIDTH(8)) uLinkDrop (
                .clk     (clk),
                .rstn    (rstn),
                .pulse   (linkDrop[p]),
                .rdClear (rd && (mgmtAddr == `PXCC_ADDR_LDROP)),
                .count   (ldCount)
            );
            pxcc_sticky_flag uEof (
                .clk     (clk),
                .rstn    (rstn),
                .pulse   (eofError[p]),
                .rdClear (rd && (mgmtAddr == `PXCC_ADDR_TENCS)),
                .flag    (eofFlag)
            );
            pxcc_sticky_flag uDisc (
                .clk     (clk),
                .rstn    (rstn),
                .pulse   (tenDisc[p]),
                .rdClear (rd && (mgmtAddr == `PXCC_ADDR_TENCS)),
                .flag    (discFlag)
            );

            // sticky control bits of the 10BASE-T register
            always @(posedge clk) begin
                if (!rstn || clrSticky) begin
                    forceLink  <= 1'b0;
                    jabDis     <= 1'b0;
                    echoDis    <= `PXCC_RST_ECHODIS;
                    hbDis      <= `PXCC_RST_HBDIS;
                    sq         <= `PXCC_RST_SQUELCH;
                    bcast      <= 1'b0;
                end else if (wr && mgmtAddr == `PXCC_ADDR_TENCS) begin
                    forceLink  <= mgmtWdata[`PXCC_BIT_FORCELINK];
                    jabDis     <= mgmtWdata[`PXCC_BIT_JABDIS];
                    echoDis    <= mgmtWdata[`PXCC_BIT_ECHODIS];
                    hbDis      <= mgmtWdata[`PXCC_BIT_HBDIS];
                    sq <= mgmtWdata[`PXCC_SQ_HI:`PXCC_SQ_LO];
                    bcast      <= mgmtWdata[`PXCC_BIT_BCAST];
                end
            end

            // super-sticky bits: only hardware reset restores them
            always @(posedge clk) begin
                if (!rstn) begin
                    stickyEn    <= `PXCC_RST_STICKYEN;
                    modeActive  <= `PXCC_RST_MODE;
                    modePending <= `PXCC_RST_MODE;
                end else begin
                    if (wr && mgmtAddr == `PXCC_ADDR_TENCS) begin
                        stickyEn <= mgmtWdata[`PXCC_BIT_STICKYEN];
                    end
                    if (wr && mgmtAddr == `PXCC_ADDR_MODE) begin
                        modePending <=
                            mgmtWdata[`PXCC_MODE_HI:`PXCC_MODE_LO];
                    end
                    if (swr) begin
                        modeActive <= modePending;
                    end
                end
            end

            // non-sticky loopbacks return to zero on any soft reset
            always @(posedge clk) begin
                if (!rstn || swr) begin
                    farLb  <= 1'b0;
                    connLb <= 1'b0;
                end else begin
                    if (wr && mgmtAddr == `PXCC_ADDR_MODE) begin
                        farLb <= mgmtWdata[`PXCC_BIT_FARLB];
                    end
                    if (wr && mgmtAddr == `PXCC_ADDR_EDGE) begin
                        connLb <= mgmtWdata[`PXCC_BIT_CONNLB];
                    end
                end
            end

            // sticky edge-rate, low power and jumbo settings
            always @(posedge clk) begin
                if (!rstn || clrSticky) begin
                    edgeSel <= `PXCC_RST_EDGE;
                    lowPwr  <= 1'b0;
                    jumbo   <= `PXCC_RST_JUMBO;
                end else if (wr && mgmtAddr == `PXCC_ADDR_EDGE) begin
                    edgeSel <= mgmtWdata[`PXCC_EDGE_HI:`PXCC_EDGE_LO];
                    lowPwr  <= mgmtWdata[`PXCC_BIT_LOWPWR];
                    jumbo   <= mgmtWdata[`PXCC_JUMBO_HI:`PXCC_JUMBO_LO];
                end
            end

            // registered link state, forced high when bypassed
            always @(posedge clk) begin
                if (!rstn) begin
                    linkNow <= 1'b0;
                end else begin
                    linkNow <= tenLinkRaw[p] | forceLink;
                end
            end

            // read word of this port, reserved bits zero
            assign rdWord[p] =
                (mgmtAddr == `PXCC_ADDR_FCAR)  ? {8'h00, fcCount} :
                (mgmtAddr == `PXCC_ADDR_LDROP) ? {8'h00, ldCount} :
                (mgmtAddr == `PXCC_ADDR_TENCS) ?
                    {forceLink, jabDis, echoDis, hbDis, sq, stickyEn,
                     eofFlag, discFlag, linkNow, 5'h00, bcastEn[p]} :
                (mgmtAddr == `PXCC_ADDR_MODE)  ?
                    {5'h00, modeActive, 4'h0, farLb, 3'h0} :
                (mgmtAddr == `PXCC_ADDR_EDGE)  ?
                    {edgeSel, lowPwr, 6'h00, jumbo, 3'h0, connLb} :
                16'h0000;

            assign bcastEn[p]           = bcast;
            assign tenLinkUp[p]         = linkNow;
            assign jabberOff[p]         = jabDis;
            assign echoOff[p]           = echoDis;
            assign heartbeatOff[p]      = hbDis;
            assign squelch[2*p+1:2*p]   = sq;
            assign mediaMode[3*p+2:3*p] = modeActive;
            assign farLoop[p]           = farLb;
            assign edgeRate[3*p+2:3*p]  = edgeSel;
            assign backplaneLowPower[p] = lowPwr;
            assign jumboMode[2*p+1:2*p] = jumbo;
            assign connLoop[p]          = connLb;
            assign softReset[p]         = swr;
        end
    endgenerate

    // read data registered from the addressed port only
    always @(posedge clk) begin
        if (!rstn) begin
            mgmtRdata <= 16'h0000;
        end else if (mgmtRd) begin
            mgmtRdata <= rdWord[mgmtPort];
        end
    end
endmodule

// >>> pxcc_port_regs_chk.sv
// concurrent checks on the port extended register bank
`timescale 1ns/1ps
module pxcc_port_regs_chk #(
    parameter PORTS = 4,
    parameter PW    = 2
) (
    input wire logic               clk,       // device clock
    input wire logic               rstn,      // reset, active low
    input wire logic [4:0]         mgmtAddr,  // register address
    input wire logic               mgmtWr,    // write strobe
    input wire logic               mgmtRd,    // read strobe
    input wire logic [15:0]        mgmtWdata, // write data
    input wire logic [15:0]        mgmtRdata, // read data
    input wire logic [PORTS-1:0]   tenLinkRaw, // raw link state
    input wire logic [PORTS-1:0]   tenLinkUp, // reported link
    input wire logic [PORTS-1:0]   jabberOff, // jabber disabled
    input wire logic [PORTS-1:0]   echoOff,   // echo disabled
    input wire logic [PORTS-1:0]   heartbeatOff, // heartbeat off
    input wire logic [2*PORTS-1:0] squelch,   // squelch select
    input wire logic [3*PORTS-1:0] mediaMode, // active media mode
    input wire logic [PORTS-1:0]   farLoop,   // far-end loopback
    input wire logic [3*PORTS-1:0] edgeRate,  // edge rate code
    input wire logic [2*PORTS-1:0] jumboMode, // jumbo select
    input wire logic [PORTS-1:0]   connLoop,  // connector loopback
    input wire logic [PORTS-1:0]   softReset  // soft reset pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // a raw link always shows as up one cycle later
    property p_link;
        1'b1 |=> ((tenLinkUp & $past(tenLinkRaw)) == $past(tenLinkRaw));
    endproperty
    a_link: assert property (p_link) else $error("link not reported");
    // active media mode only moves on a soft reset
    property p_mode; (softReset == '0) |=> $stable(mediaMode); endproperty
    a_mode: assert property (p_mode) else $error("media mode moved");
    // soft reset only from a control write with bit 15
    property p_swr;
        (|softReset) |-> (mgmtWr && mgmtAddr == 5'h00 && mgmtWdata[15]);
    endproperty
    a_swr: assert property (p_swr) else $error("spurious soft reset");
    // sticky controls hold without a write
    property p_stky;
        !mgmtWr |=> $stable({jabberOff, echoOff, heartbeatOff, squelch,
                             edgeRate, jumboMode});
    endproperty
    a_stky: assert property (p_stky) else $error("sticky moved");
    // loopback enables hold without a write
    property p_loop; !mgmtWr |=> $stable({farLoop, connLoop}); endproperty
    a_loop: assert property (p_loop) else $error("loopback moved");
    // counter reads carry a zero upper byte
    property p_rsv1;
        mgmtRd && (mgmtAddr == 5'h14 || mgmtAddr == 5'h15)
            |=> mgmtRdata[15:8] == 8'h00;
    endproperty
    a_rsv1: assert property (p_rsv1) else $error("counter high byte");
    // reserved status bits read zero
    property p_rsv2; mgmtRd && mgmtAddr == 5'h16 |=> mgmtRdata[5:1] == 5'h00;
    endproperty
    a_rsv2: assert property (p_rsv2) else $error("status reserved");
    // reserved control bits of the edge-rate control word read zero
    property p_rsv3;
        mgmtRd && mgmtAddr == 5'h18 |=> {mgmtRdata[11:6], mgmtRdata[3:1]} == 9'h0
            and $past(mgmtAddr) == 5'h18;
    endproperty
    a_rsv3: assert property (p_rsv3) else $error("edge reserved");
    // unmapped reads return zero
    property p_unmap;
        mgmtRd && (mgmtAddr < 5'h14 || mgmtAddr > 5'h18)
            |=> mgmtRdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
endmodule
bind pxcc_port_regs pxcc_port_regs_chk #(.PORTS(PORTS), .PW(PW)) chk (
    .clk(clk), .rstn(rstn), .mgmtAddr(mgmtAddr), .mgmtWr(mgmtWr),
    .mgmtRd(mgmtRd), .mgmtWdata(mgmtWdata), .mgmtRdata(mgmtRdata),
    .tenLinkRaw(tenLinkRaw), .tenLinkUp(tenLinkUp), .jabberOff(jabberOff),
    .echoOff(echoOff), .heartbeatOff(heartbeatOff), .squelch(squelch),
    .mediaMode(mediaMode), .farLoop(farLoop), .edgeRate(edgeRate),
    .jumboMode(jumboMode), .connLoop(connLoop), .softReset(softReset));

// >>> pxcc_mgmt_host.sv
// management station model issuing register reads and writes
`timescale 1ns/1ps
module pxcc_mgmt_host (
    input  wire logic        clk,       // device clock
    input  wire logic [15:0] mgmtRdata, // read data from the bank
    output logic      [1:0]  mgmtPort,  // addressed port
    output logic      [4:0]  mgmtAddr,  // register address
    output logic             mgmtWr,    // write strobe
    output logic             mgmtRd,    // read strobe
    output logic      [15:0] mgmtWdata  // write data
);
    // idle bus at time zero
    initial begin
        mgmtPort = 2'h0;
        mgmtAddr = 5'h00;
        mgmtWr = 1'b0;
        mgmtRd = 1'b0;
        mgmtWdata = 16'h0000;
    end
    // one write, taken at the next edge; also issues soft resets
    task automatic wr(input [1:0] p, input [4:0] a, input [15:0] d);
        @(posedge clk);
        mgmtPort <= p;
        mgmtAddr <= a;
        mgmtWdata <= d;
        mgmtWr <= 1'b1;
        @(posedge clk);
        mgmtWr <= 1'b0;
        mgmtWdata <= ~d; // released data does not linger
    endtask
    // one read, data taken one cycle after the strobe
    task automatic rd(input [1:0] p, input [4:0] a, output [15:0] d);
        @(posedge clk);
        mgmtPort <= p;
        mgmtAddr <= a;
        mgmtRd <= 1'b1;
        @(posedge clk);
        mgmtRd <= 1'b0;
        @(posedge clk);
        d = mgmtRdata;
    endtask
endmodule

// >>> pxcc_port_regs_bench.sv
// self-checking bench for the port extended register bank
`timescale 1ns/1ps
module pxcc_port_regs_bench;
    reg          clk, rstn;
    reg  [3:0]   falseCarrier, linkDrop, eofError, tenDisc, tenLinkRaw;
    wire [1:0]   mgmtPort;
    wire [4:0]   mgmtAddr;
    wire         mgmtWr, mgmtRd;
    wire [15:0]  mgmtWdata, mgmtRdata;
    wire [3:0]   tenLinkUp, jabberOff, echoOff, heartbeatOff, farLoop;
    wire [3:0]   backplaneLowPower, connLoop, softReset;
    wire [7:0]   squelch, jumboMode;
    wire [11:0]  mediaMode, edgeRate;
    integer      n_errors, checks, i, swCount;
    reg  [15:0]  d;
    pxcc_port_regs #(.PORTS(4), .PW(2)) DUT (.clk(clk), .rstn(rstn),
        .mgmtPort(mgmtPort), .mgmtAddr(mgmtAddr), .mgmtWr(mgmtWr),
        .mgmtRd(mgmtRd), .mgmtWdata(mgmtWdata), .mgmtRdata(mgmtRdata),
        .falseCarrier(falseCarrier), .linkDrop(linkDrop), .eofError(eofError),
        .tenDisc(tenDisc), .tenLinkRaw(tenLinkRaw), .tenLinkUp(tenLinkUp),
        .jabberOff(jabberOff), .echoOff(echoOff), .heartbeatOff(heartbeatOff),
        .squelch(squelch), .mediaMode(mediaMode), .farLoop(farLoop),
        .edgeRate(edgeRate), .backplaneLowPower(backplaneLowPower),
        .jumboMode(jumboMode), .connLoop(connLoop), .softReset(softReset));
    pxcc_mgmt_host host (.clk(clk), .mgmtRdata(mgmtRdata),
        .mgmtPort(mgmtPort), .mgmtAddr(mgmtAddr), .mgmtWr(mgmtWr),
        .mgmtRd(mgmtRd), .mgmtWdata(mgmtWdata));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // count soft reset pulses seen on port 2
    always @(posedge clk) begin
        if (softReset[2] === 1'b1) swCount <= swCount + 1;
    end
    // compare and count
    task chk(input [15:0] got, input [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read a register and compare
    task rc(input [1:0] p, input [4:0] a, input [15:0] e);
        reg [15:0] v;
        host.rd(p, a, v);
        chk(v, e);
    endtask
    // n one-cycle pulses of event kind k on port p
    task ev(input integer k, input integer p, input integer n);
        repeat (n) begin
            @(posedge clk);
            case (k)
                0: falseCarrier[p] <= 1'b1;
                1: linkDrop[p] <= 1'b1;
                2: eofError[p] <= 1'b1;
                default: tenDisc[p] <= 1'b1;
            endcase
            @(posedge clk);
            {falseCarrier, linkDrop, eofError, tenDisc} <= 16'h0000;
        end
    endtask
    // verdict and end of run
    task results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        n_errors = n_errors + 1;
        $display("ERROR %0t: run timed out", $time);
        results;
    end
    // main sequence
    initial begin
        rstn = 1'b0;
        {falseCarrier, linkDrop, eofError, tenDisc, tenLinkRaw} = 20'h00000;
        n_errors = 0;
        checks = 0;
        swCount = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rc(0, 5'h14, 16'h0000);
        rc(0, 5'h16, 16'h3200);
        rc(0, 5'h17, 16'h0000);
        rc(0, 5'h18, 16'h2000);
        ev(0, 1, 3);
        rc(1, 5'h14, 16'h0003);
        rc(1, 5'h14, 16'h0000);
        ev(1, 2, 260);
        rc(2, 5'h15, 16'h00ff);
        rc(3, 5'h15, 16'h0000);
        tenLinkRaw <= 4'h1;
        ev(2, 0, 1);
        ev(3, 0, 1);
        rc(0, 5'h16, 16'h33c0);
        rc(0, 5'h16, 16'h3240);
        // force link, jabber off, low squelch on port 3
        host.wr(3, 5'h16, 16'hf600);
        repeat (2) @(posedge clk);
        chk({jabberOff[3], heartbeatOff[3], squelch[7:6]}, 16'h000d);
        chk(tenLinkUp, 16'h0009);
        host.rd(3, 5'h16, d);
        chk(d, 16'hf640);
        for (i = 0; i < 3; i = i + 1) begin
            host.wr(2, 5'h16, 16'h3200 | (i[15:0] << 10));
            @(posedge clk);
            chk({14'h0, squelch[5:4]}, i[15:0]);
        end
        // broadcast writes, per-port reads
        host.wr(0, 5'h16, 16'h3201);
        host.wr(0, 5'h18, 16'hc010);
        ev(0, 1, 2);
        for (i = 0; i < 4; i = i + 1)
            rc(i[1:0], 5'h18, 16'hc010);
        chk({4'h0, edgeRate}, 16'h0db6);
        chk({8'h0, jumboMode}, 16'h0055);
        rc(0, 5'h14, 16'h0000);
        rc(1, 5'h14, 16'h0002);
        host.wr(0, 5'h16, 16'h3200);
        host.wr(1, 5'h18, 16'h7021);
        rc(1, 5'h18, 16'h7021);
        chk({8'h0, echoOff, backplaneLowPower}, 16'h00f2);
        chk({12'h0, connLoop}, 16'h0002);
        rc(2, 5'h18, 16'hc010);
        // media mode waits for soft reset, survives sticky-off reset
        host.wr(2, 5'h17, 16'h0308);
        rc(2, 5'h17, 16'h0008);
        chk({12'h0, farLoop}, 16'h0004);
        host.wr(2, 5'h00, 16'h8000);
        rc(2, 5'h17, 16'h0300);
        chk({4'h0, mediaMode}, 16'h00c0);
        rc(2, 5'h18, 16'hc010);
        host.wr(2, 5'h16, 16'h3000);
        host.wr(2, 5'h18, 16'h6020);
        host.wr(2, 5'h00, 16'h8000);
        rc(2, 5'h18, 16'h2000);
        rc(2, 5'h16, 16'h3000);
        rc(2, 5'h17, 16'h0300);
        // unmapped and read-only places ignore writes
        host.wr(1, 5'h1f, 16'hffff);
        rc(1, 5'h1f, 16'h0000);
        host.wr(0, 5'h14, 16'hffff);
        rc(0, 5'h14, 16'h0000);
        chk(swCount[15:0], 16'h0002);
        results;
    end
endmodule
